// ### core/bsram_cfg.svh
// Purpose: shared constants of the burst SRAM link and its two ends
// Assumes: included by bare name, once per compile unit
// Notes: the array depth is a model depth, far below the real part
`ifndef BSRAM_CFG_SVH
`define BSRAM_CFG_SVH
`define BSRAM_DQ_W 36
`define BSRAM_ADDR_W 22
`define BSRAM_SEL_W 4
`define BSRAM_LANE_W 9
`define BSRAM_NIB_W 4
`define BSRAM_MEM_AW 10
`define BSRAM_RW_TURN 2
`define BSRAM_PH_DECIDE 2'h2
`define BSRAM_PH_WORD1 2'h0
`define BSRAM_PH_SAMPLE1 2'h0
`define BSRAM_PH_SAMPLE0 2'h2
`endif

// ### core/bsram_pkg.sv
// Purpose: types shared by both ends of the burst SRAM link
// Assumes: nothing
// Notes: organisation decides how write selects map onto data bits
package bsram_pkg;
   typedef enum logic [1:0] {BSRAM_ORG_X8, BSRAM_ORG_X9, BSRAM_ORG_X18, BSRAM_ORG_X36} bsram_org_t;
endpackage

// ### core/bsram_if.sv
// Purpose: pin bundle between memory controller and burst SRAM
// Assumes: host makes the complementary clock pair
// Notes: the shared data wire is resolved here from the two enables
`timescale 1ns/10ps
`include "bsram_cfg.svh"
interface bsram_if;
   logic k;                                    // positive input clock
   logic k_b;                                  // negative input clock
   logic load_strobe_n;                        // command strobe, low = start
   logic rd_wr_sel;                            // high = read, low = write
   logic [`BSRAM_ADDR_W-1:0] addr;             // burst start address
   logic [`BSRAM_SEL_W-1:0] byte_write_select_n; // lane selects, low = write
   logic latency_select_pin;                   // high = two-cycle read latency
   logic [`BSRAM_DQ_W-1:0] h_dq;               // host drive value
   logic h_dq_oe;                              // host drives data wire
   logic [`BSRAM_DQ_W-1:0] d_dq;               // device drive value
   logic d_dq_oe;                              // device drives data wire
   logic [`BSRAM_DQ_W-1:0] dq;                 // resolved data wire
   logic clash;                                // both ends drive at once
   // nobody driving reads as zero; clash flags contention
   assign dq = d_dq_oe ? d_dq : (h_dq_oe ? h_dq : '0);
   assign clash = d_dq_oe & h_dq_oe;
   modport dev (input k, k_b, load_strobe_n, rd_wr_sel, addr, byte_write_select_n,
                latency_select_pin, dq, output d_dq, d_dq_oe);
   modport host (output k, k_b, load_strobe_n, rd_wr_sel, addr, byte_write_select_n,
                 latency_select_pin, h_dq, h_dq_oe, input dq);
endinterface

// ### core/bsram_dev.sv
// Purpose: burst SRAM end: command decode, two-word bursts, lane masks
// Assumes: host keeps the command and data timing on the pin pair
// Notes: runs entirely on the link clock pair, no clock of its own
// Function
// - write starts; data follows one cycle later
// - read starts; data returns two cycles later
// - t counts cycles from command start
// - first word address A, second word also at address A
// - data in and out on both clocks
// - powers up deselected, outputs tristated
// - stopped clocks hold pins in previous state
// - x8: nibble selects gate bits 3:0, 7:4
// - x18: byte selects gate bits 8:0, 17:9
// - x8/x18 both selects high writes nothing
// - x9: single select gates bits 8:0
// - x36: select n gates lane 9n
// - host may change selects between edges
// - latency pin low gives one-cycle reads
// - deselect: finish reads, tristate after rise
// - host inserts two idle cycles read-write
// - read after write returns newest data
`timescale 1ns/10ps
`include "bsram_cfg.svh"
module bsram_dev
   import bsram_pkg::*;
(
   bsram_if.dev link,          // pins toward the controller
   input wire logic rst_b,     // async reset, active low
   input wire logic ce,        // freezes all state while low
   input wire bsram_org_t org  // organisation strap
);
   localparam int DW = `BSRAM_DQ_W;
   localparam int AW = `BSRAM_ADDR_W;
   localparam int MAW = `BSRAM_MEM_AW;
   localparam int LW = `BSRAM_LANE_W;
   localparam int NW = `BSRAM_NIB_W;
   localparam int SW = `BSRAM_SEL_W;

   // ********************************************
   // straps, caught on the positive clock
   // ********************************************
   logic [1:0] lat_sync_ff;    // latency pin synchroniser
   bsram_org_t org_s1_ff;      // organisation first stage
   bsram_org_t org_ff;         // organisation in use
   wire lat_two = lat_sync_ff[1]; // two-cycle read latency

   // straps are static; two stages keep power-up edges clean
   always_ff @(posedge link.k or negedge rst_b) begin
      if (!rst_b) begin
         lat_sync_ff <= 2'h0;
         org_s1_ff <= BSRAM_ORG_X8;
         org_ff <= BSRAM_ORG_X8;
      end else if (ce) begin
         lat_sync_ff <= {lat_sync_ff[0], link.latency_select_pin};
         org_s1_ff <= org;
         org_ff <= org_s1_ff;
      end
   end

   // ********************************************
   // per-bit write masks and width
   // ********************************************
   logic [DW-1:0] lane_on;     // bit exists in this organisation
   logic [DW-1:0] bit_sel_n;   // select governing this bit
   logic [DW-1:0] live_mask;   // bits to write on this data edge

   // x8 reuses select bits [1:0] as its two nibble selects
   for (genvar gi = 0; gi < DW; gi++) begin : g_mask
      localparam int NIB = (gi / NW) % SW; // nibble select in x8
      localparam int BYT = gi / LW;        // nine-bit lane otherwise
      assign lane_on[gi] = (org_ff == BSRAM_ORG_X36) ? 1'b1 :
                           (org_ff == BSRAM_ORG_X18) ? (gi < 2 * LW) :
                           (org_ff == BSRAM_ORG_X9) ? (gi < LW) :
                           (gi < 2 * NW);
      assign bit_sel_n[gi] = (org_ff == BSRAM_ORG_X8) ? link.byte_write_select_n[NIB] :
                             link.byte_write_select_n[BYT];
      // a high select leaves the bit unaltered; all high writes nothing
      assign live_mask[gi] = lane_on[gi] & ~bit_sel_n[gi];
   end

   // ********************************************
   // command pipeline, positive clock
   // ********************************************
   // read/write select only counts while the strobe is low
   wire cmd_rd = ~link.load_strobe_n & link.rd_wr_sel;
   wire cmd_wr = ~link.load_strobe_n & ~link.rd_wr_sel;
   logic rd_d1_ff;             // read started last rise
   logic rd_d2_ff;             // read started two rises ago
   logic wr_d1_ff;             // write started last rise
   logic wr_d2_ff;             // write started two rises ago
   logic [AW-1:0] addr_d1_ff;  // address of last command
   logic [AW-1:0] addr_d2_ff;  // address one stage older
   logic [DW-1:0] w0_ff;       // first burst word
   logic [DW-1:0] m0_ff;       // first word mask

   // idle cycles (strobe high) clear both flags, rw ignored
   always_ff @(posedge link.k or negedge rst_b) begin
      if (!rst_b) begin
         rd_d1_ff <= 1'b0;
         rd_d2_ff <= 1'b0;
         wr_d1_ff <= 1'b0;
         wr_d2_ff <= 1'b0;
         addr_d1_ff <= '0;
         addr_d2_ff <= '0;
      end else if (ce) begin
         rd_d1_ff <= cmd_rd;
         wr_d1_ff <= cmd_wr;
         rd_d2_ff <= rd_d1_ff;
         wr_d2_ff <= wr_d1_ff;
         addr_d1_ff <= link.addr;
         addr_d2_ff <= addr_d1_ff;
      end
   end

   // first word lands on the rise after the command
   always_ff @(posedge link.k or negedge rst_b) begin
      if (!rst_b) begin
         w0_ff <= '0;
         m0_ff <= '0;
      end else if (ce) begin
         if (wr_d1_ff) begin
            w0_ff <= link.dq;
            m0_ff <= live_mask;
         end
      end
   end

   // ********************************************
   // second data edge, negative clock
   // ********************************************
   logic [DW-1:0] w1_ff;       // second burst word
   logic [DW-1:0] m1_ff;       // second word mask
   logic [DW-1:0] q1_ff;       // second read word on the pins

   // wr_d2 is the burst whose first word was just taken
   always_ff @(posedge link.k_b or negedge rst_b) begin
      if (!rst_b) begin
         w1_ff <= '0;
         m1_ff <= '0;
      end else if (ce) begin
         if (wr_d2_ff) begin
            w1_ff <= link.dq;
            m1_ff <= live_mask;
         end
      end
   end

   // ********************************************
   // array, commit and read
   // ********************************************
   // no reset on the array: rows read undefined until written
   logic [DW-1:0] mem [0:(2**(MAW+1))-1]; // two words per address
   wire [MAW-1:0] wr_row = addr_d2_ff[MAW-1:0];
   wire rd_go = lat_two ? rd_d2_ff : rd_d1_ff;
   wire [AW-1:0] rd_addr = lat_two ? addr_d2_ff : addr_d1_ff;
   wire [MAW-1:0] rd_row = rd_addr[MAW-1:0];
   wire [DW-1:0] arr0 = mem[{rd_row, 1'b0}];
   wire [DW-1:0] arr1 = mem[{rd_row, 1'b1}];
   // one-cycle reads can meet a commit of the same address on this edge
   wire byp = wr_d2_ff & (addr_d2_ff == rd_addr);
   wire [DW-1:0] rd0 = byp ? ((arr0 & ~m0_ff) | (w0_ff & m0_ff)) : arr0;
   wire [DW-1:0] rd1 = byp ? ((arr1 & ~m1_ff) | (w1_ff & m1_ff)) : arr1;
   logic [DW-1:0] q0_ff;       // first read word on the pins
   logic [DW-1:0] q1_pend_ff;  // second word waiting for its edge
   logic oe_ff;                // device owns the data wire

   // both words commit together once the second has arrived
   always_ff @(posedge link.k) begin
      if (ce && wr_d2_ff) begin
         mem[{wr_row, 1'b0}] <= (mem[{wr_row, 1'b0}] & ~m0_ff) | (w0_ff & m0_ff);
         mem[{wr_row, 1'b1}] <= (mem[{wr_row, 1'b1}] & ~m1_ff) | (w1_ff & m1_ff);
      end
   end

   // output enable follows read data only; next rise without read drops it
   always_ff @(posedge link.k or negedge rst_b) begin
      if (!rst_b) begin
         oe_ff <= 1'b0;
         q0_ff <= '0;
         q1_pend_ff <= '0;
      end else if (ce) begin
         oe_ff <= rd_go;
         if (rd_go) begin
            q0_ff <= rd0 & lane_on;
            q1_pend_ff <= rd1 & lane_on;
         end
      end
   end

   // second word launched on the negative clock rise
   always_ff @(posedge link.k_b or negedge rst_b) begin
      if (!rst_b) begin
         q1_ff <= '0;
      end else if (ce) begin
         q1_ff <= q1_pend_ff;
      end
   end

   // ********************************************
   // pins
   // ********************************************
   // k high shows the word launched on its rise, k low the other;
   // stopped clocks leave the pins where they were
   // ce is read on link clock rises; move it only while the pair is
   // still, or this end slips one edge against the controller
   assign link.d_dq = link.k ? q0_ff : q1_ff;
   assign link.d_dq_oe = oe_ff;
endmodule

// ### core/bsram_host.sv
// Purpose: memory controller end: issues bursts, makes the clock pair
// Assumes: device end follows the pin timing of the burst SRAM
// Notes: link clock is the system clock divided by four
`timescale 1ns/10ps
`include "bsram_cfg.svh"
module bsram_host
   import bsram_pkg::*;
(
   input wire logic clock,                          // system clock
   input wire logic rst_b,                          // async reset, active low
   input wire logic ce,                             // freezes all state while low
   input wire logic lat_two,                        // drive two-cycle latency mode
   input wire logic req_valid,                      // request offered
   output logic req_ready,                          // request taken this cycle
   input wire logic req_write,                      // high = write burst
   input wire logic [`BSRAM_ADDR_W-1:0] req_addr,   // burst address
   input wire logic [`BSRAM_DQ_W-1:0] req_wdata0,   // first write word
   input wire logic [`BSRAM_DQ_W-1:0] req_wdata1,   // second write word
   input wire logic [`BSRAM_SEL_W-1:0] req_sel0_n,  // first word selects
   input wire logic [`BSRAM_SEL_W-1:0] req_sel1_n,  // second word selects
   output logic rsp_valid,                          // read words ready, pulse
   output logic [`BSRAM_DQ_W-1:0] rsp_rdata0,       // first read word
   output logic [`BSRAM_DQ_W-1:0] rsp_rdata1,       // second read word
   bsram_if.host link                               // pins toward the SRAM
);
   localparam int DW = `BSRAM_DQ_W;
   localparam int AW = `BSRAM_ADDR_W;
   localparam int SW = `BSRAM_SEL_W;

   // ********************************************
   // clock pair divider
   // ********************************************
   logic [1:0] ph_ff;          // quarter of the link period
   // command and data pins never change on a clock-pair rise, so the far end sees no race
   wire decide = (ph_ff == `BSRAM_PH_DECIDE);
   wire word1_edge = (ph_ff == `BSRAM_PH_WORD1);
   wire rise_edge = (ph_ff == 2'h3);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ph_ff <= 2'h0;
      end else if (ce) begin
         ph_ff <= ph_ff + 2'h1;
      end
   end
   // phase 0 and 1 high; parks high when reset
   assign link.k = ~ph_ff[1];
   assign link.k_b = ph_ff[1];

   // ********************************************
   // issue and turnaround
   // ********************************************
   logic [1:0] gap_ff;         // idle cycles since last read
   logic ld_n_ff;              // load strobe pin
   logic rw_ff;                // read/write select pin
   logic [AW-1:0] addr_ff;     // address pin
   logic lat_ff;               // latency pin
   wire wr_ok = (gap_ff >= 2'(`BSRAM_RW_TURN));
   assign req_ready = decide & (~req_write | wr_ok);
   wire take = req_valid & req_ready;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         gap_ff <= 2'h3;
         ld_n_ff <= 1'b1;
         rw_ff <= 1'b1;
         addr_ff <= '0;
         lat_ff <= 1'b0;
      end else if (ce) begin
         lat_ff <= lat_two;
         if (decide) begin
            ld_n_ff <= ~take;
            if (take) begin
               rw_ff <= ~req_write;
               addr_ff <= req_addr;
            end
            if (take && !req_write) begin
               gap_ff <= 2'h0;
            end else if (gap_ff != 2'h3) begin
               gap_ff <= gap_ff + 2'h1;
            end
         end
      end
   end

   // ********************************************
   // write data staging
   // ********************************************
   logic a_vld_ff;             // write issued, words not yet sent
   logic [DW-1:0] a_w0_ff;     // staged first word
   logic [DW-1:0] a_w1_ff;     // staged second word
   logic [SW-1:0] a_s0_ff;     // staged first selects
   logic [SW-1:0] a_s1_ff;     // staged second selects
   logic b_vld_ff;             // second word due next
   logic [DW-1:0] b_w1_ff;     // second word in flight
   logic [SW-1:0] b_s1_ff;     // second selects in flight
   logic [DW-1:0] dq_ff;       // data pin value
   logic dq_oe_ff;             // data pin enable
   logic [SW-1:0] sel_ff;      // select pins

   // word0 goes out a cycle after its command, word1 half a cycle later
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         a_vld_ff <= 1'b0;
         a_w0_ff <= '0;
         a_w1_ff <= '0;
         a_s0_ff <= '1;
         a_s1_ff <= '1;
         b_vld_ff <= 1'b0;
         b_w1_ff <= '0;
         b_s1_ff <= '1;
         dq_ff <= '0;
         dq_oe_ff <= 1'b0;
         sel_ff <= '1;
      end else if (ce) begin
         if (decide) begin
            a_vld_ff <= take & req_write;
            a_w0_ff <= req_wdata0;
            a_w1_ff <= req_wdata1;
            a_s0_ff <= req_sel0_n;
            a_s1_ff <= req_sel1_n;
            b_vld_ff <= a_vld_ff;
            b_w1_ff <= a_w1_ff;
            b_s1_ff <= a_s1_ff;
            dq_oe_ff <= a_vld_ff;
            dq_ff <= a_w0_ff;
            sel_ff <= a_vld_ff ? a_s0_ff : '1;
         end else if (word1_edge && b_vld_ff) begin
            dq_ff <= b_w1_ff;
            sel_ff <= b_s1_ff;
         end
      end
   end
   assign link.load_strobe_n = ld_n_ff;
   assign link.rd_wr_sel = rw_ff;
   assign link.addr = addr_ff;
   assign link.latency_select_pin = lat_ff;
   assign link.byte_write_select_n = sel_ff;
   assign link.h_dq = dq_ff;
   assign link.h_dq_oe = dq_oe_ff;

   // ********************************************
   // read capture
   // ********************************************
   logic [DW-1:0] dq_s1_ff;    // data pin first stage
   logic [DW-1:0] dq_s2_ff;    // data pin second stage
   logic [3:0] rd_sh_ff;       // reads seen on each rise
   wire take0 = lat_ff ? rd_sh_ff[2] : rd_sh_ff[1];
   wire take1 = lat_ff ? rd_sh_ff[3] : rd_sh_ff[2];

   // two stages cost a fixed delay, counted into the capture phases
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dq_s1_ff <= '0;
         dq_s2_ff <= '0;
         rd_sh_ff <= 4'h0;
         rsp_valid <= 1'b0;
         rsp_rdata0 <= '0;
         rsp_rdata1 <= '0;
      end else if (ce) begin
         dq_s1_ff <= link.dq;
         dq_s2_ff <= dq_s1_ff;
         rsp_valid <= 1'b0;
         if (rise_edge) begin
            rd_sh_ff <= {rd_sh_ff[2:0], ~ld_n_ff & rw_ff};
         end
         if (ph_ff == `BSRAM_PH_SAMPLE0 && take0) begin
            rsp_rdata0 <= dq_s2_ff;
         end
         if (ph_ff == `BSRAM_PH_SAMPLE1 && take1) begin
            rsp_rdata1 <= dq_s2_ff;
            rsp_valid <= 1'b1;
         end
      end
   end
endmodule

// ### testbench/bsram_link_monitor.sv
// Purpose: pin-level checker for the burst SRAM link
// Assumes: latency pin is changed only while the link is idle
// Notes: every check runs on rises of the positive link clock
`timescale 1ns/10ps
module bsram_link_monitor
   import bsram_pkg::*;
(
   input wire logic k,                  // positive link clock
   input wire logic rst_b,              // async reset, active low
   input wire logic load_strobe_n,      // command strobe, low = start
   input wire logic rd_wr_sel,          // high = read
   input wire logic latency_select_pin, // high = two-cycle reads
   input wire logic h_dq_oe,            // host drives data wire
   input wire logic d_dq_oe,            // device drives data wire
   input wire logic clash               // both ends drive at once
);
   // ****************
   // command decode
   // ****************
   logic rd2;                // read, two-cycle latency
   logic rd1;                // read, one-cycle latency
   logic wr;                 // write start
   logic [1:0] rise_cnt_ff;  // k rises since reset, saturating
   logic [1:0] nxt_rise_cnt; // next count
   assign rd2 = !load_strobe_n && rd_wr_sel && latency_select_pin;
   assign rd1 = !load_strobe_n && rd_wr_sel && !latency_select_pin;
   assign wr = !load_strobe_n && !rd_wr_sel;
   assign nxt_rise_cnt = (rise_cnt_ff == 2'h3) ? rise_cnt_ff : rise_cnt_ff + 2'h1;
   // small counter: only the power-up check needs it
   always_ff @(posedge k or negedge rst_b) begin
      if (!rst_b) begin
         rise_cnt_ff <= 2'h0;
      end else begin
         rise_cnt_ff <= nxt_rise_cnt;
      end
   end
   // ****************
   // sequences and checks
   // ****************
   default clocking mon_cb @(posedge k);
   endclocking
   default disable iff (!rst_b);
   sequence s_rd2;
      rd2;
   endsequence
   sequence s_rd1;
      rd1;
   endsequence
   sequence s_wr;
      wr;
   endsequence
   sequence s_idle3;
      load_strobe_n [*3];
   endsequence
   // sampled values lag one k rise, hence the extra cycle on outputs
   AST_NO_CLASH: assert property (!clash)
      else $error("both ends drive the data wire");
   AST_RD_LAT2: assert property (s_rd2 |-> ##3 d_dq_oe)
      else $error("two-cycle read data missing");
   AST_RD_LAT1: assert property (s_rd1 |-> ##2 d_dq_oe)
      else $error("one-cycle read data missing");
   AST_OE_CAUSE: assert property (d_dq_oe |-> $past(rd2, 3) || $past(rd1, 2))
      else $error("device drives without a read");
   AST_IDLE_QUIET: assert property (s_idle3 |=> !d_dq_oe)
      else $error("device drives after idle cycles");
   AST_WR_BUS_FREE: assert property (s_wr |-> ##1 !d_dq_oe ##1 !d_dq_oe)
      else $error("device drives during write data");
   AST_WR_HOST_DATA: assert property (s_wr |-> ##1 h_dq_oe)
      else $error("host write data absent at next rise");
   AST_RD_WR_GAP: assert property ((rd1 || rd2) |-> ##1 !wr ##1 !wr)
      else $error("write too soon after read");
   AST_PWRUP_QUIET: assert property (rise_cnt_ff != 2'h3 |-> !d_dq_oe)
      else $error("device drives right after reset");
endmodule

// ### testbench/burst_sram_cmd_byte_write_tb.sv
// Purpose: end-to-end bench of controller and burst SRAM ends
// Assumes: link clock is made by the host from the system clock
// Notes: a word model with lane masks predicts every read burst
`timescale 1ns/10ps
`include "bsram_cfg.svh"
module burst_sram_cmd_byte_write_tb
   import bsram_pkg::*;
;
   // ****************
   // signals
   // ****************
   logic clock;              // system clock
   logic rst_b;              // reset, active low
   logic ce;                 // run enable of both ends
   logic lat_two;            // two-cycle latency mode
   logic req_valid;          // request offered
   logic req_ready;          // request taken
   logic req_write;          // write burst
   logic [21:0] req_addr;    // burst address
   logic [35:0] req_wdata0;  // first write word
   logic [35:0] req_wdata1;  // second write word
   logic [3:0] req_sel0_n;   // first word selects
   logic [3:0] req_sel1_n;   // second word selects
   logic rsp_valid;          // read done pulse
   logic [35:0] rsp_rdata0;  // first read word
   logic [35:0] rsp_rdata1;  // second read word
   bsram_org_t org;          // organisation strap
   int n_errors;             // mismatches
   int comparisons;          // checks made
   int cycles;               // hang guard
   logic [35:0] mem [0:31];  // model: two beats per address
   logic [71:0] exp_q [$];   // outstanding read bursts
   logic [35:0] hold_dq;     // data wire at clock stop
   bsram_if link_bus ();
   bsram_host u_bsram_host (.clock(clock), .rst_b(rst_b), .ce(ce), .lat_two(lat_two),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_addr(req_addr), .req_wdata0(req_wdata0), .req_wdata1(req_wdata1),
      .req_sel0_n(req_sel0_n), .req_sel1_n(req_sel1_n), .rsp_valid(rsp_valid),
      .rsp_rdata0(rsp_rdata0), .rsp_rdata1(rsp_rdata1), .link(link_bus.host));
   bsram_dev u_bsram_dev (.link(link_bus.dev), .rst_b(rst_b), .ce(ce), .org(org));
   bsram_link_monitor u_bsram_link_monitor (.k(link_bus.k), .rst_b(rst_b),
      .load_strobe_n(link_bus.load_strobe_n), .rd_wr_sel(link_bus.rd_wr_sel),
      .latency_select_pin(link_bus.latency_select_pin), .h_dq_oe(link_bus.h_dq_oe),
      .d_dq_oe(link_bus.d_dq_oe), .clash(link_bus.clash));
   always #10 clock = ~clock;
   // ****************
   // model and helpers
   // ****************
   // bits written for one data edge; a select high keeps the lane
   function automatic logic [35:0] lane_mask(bsram_org_t o, logic [3:0] s);
      case (o)
         BSRAM_ORG_X8: lane_mask = {28'h0, {4{~s[1]}}, {4{~s[0]}}};
         BSRAM_ORG_X9: lane_mask = {27'h0, {9{~s[0]}}};
         BSRAM_ORG_X18: lane_mask = {18'h0, {9{~s[1]}}, {9{~s[0]}}};
         default: lane_mask = {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
      endcase
   endfunction
   task automatic check(input string what, input logic [71:0] exp, input logic [71:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // one burst; held until taken, model updated at acceptance
   task automatic issue(input logic wr, input int a, input logic [3:0] s0,
                        input logic [3:0] s1);
      logic [35:0] w0;
      logic [35:0] w1;
      logic [35:0] wid;
      int spin;
      w0 = 36'({$urandom(), $urandom()});
      w1 = 36'({$urandom(), $urandom()});
      wid = lane_mask(org, 4'h0);
      spin = 0;
      @(posedge clock);
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr <= 22'(a);
      req_wdata0 <= w0;
      req_wdata1 <= w1;
      req_sel0_n <= s0;
      req_sel1_n <= s1;
      do begin
         @(negedge clock);
         spin++;
      end while (req_ready !== 1'b1 && spin < 64);
      check("req_ready", 72'h1, {71'h0, req_ready});
      @(posedge clock);
      req_valid <= 1'b0;
      if (wr) begin
         mem[2*a] = (mem[2*a] & ~lane_mask(org, s0)) | (w0 & lane_mask(org, s0));
         mem[2*a+1] = (mem[2*a+1] & ~lane_mask(org, s1)) | (w1 & lane_mask(org, s1));
      end else begin
         exp_q.push_back({mem[2*a] & wid, mem[2*a+1] & wid});
      end
   endtask
   // straps and latency may only move once every burst has retired
   task automatic drain();
      while (exp_q.size() != 0) @(posedge clock);
      repeat (16) @(posedge clock);
   endtask
   // each response pulse retires the oldest read
   always @(negedge clock) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("rsp_spurious", 72'h0, 72'h1);
         end else begin
            check("rsp_rdata", exp_q.pop_front(), {rsp_rdata0, rsp_rdata1});
         end
      end
   end
   // hang guard, far above the expected run of about 1300 clocks
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         test_done();
      end
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      clock = 1'b0;
      rst_b = 1'b0;
      ce = 1'b1;
      lat_two = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 22'h0;
      req_wdata0 = 36'h0;
      req_wdata1 = 36'h0;
      req_sel0_n = 4'hF;
      req_sel1_n = 4'hF;
      org = BSRAM_ORG_X36;
      n_errors = 0;
      comparisons = 0;
      cycles = 0;
      void'($urandom(42));
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      @(negedge clock);
      check("powerup_oe", 72'h0, {71'h0, link_bus.d_dq_oe});
      repeat (40) @(posedge clock);
      for (int a = 0; a < 16; a++) issue(1'b1, a, 4'h0, 4'h0);
      // every organisation: masked writes, then back-to-back reads
      for (int o = 0; o < 4; o++) begin
         drain();
         org <= bsram_org_t'(o);
         repeat (40) @(posedge clock);
         issue(1'b1, o, 4'h0, 4'hF);
         repeat (8) issue(1'b1, $urandom_range(15), 4'($urandom()), 4'($urandom()));
         for (int a = 0; a < 16; a++) issue(1'b0, a, 4'h0, 4'h0);
      end
      // one-cycle mode: mixed traffic on few addresses
      drain();
      lat_two <= 1'b0;
      repeat (40) @(posedge clock);
      repeat (60) issue(1'($urandom_range(1)), $urandom_range(3), 4'($urandom()),
                        4'($urandom()));
      // stop the clocks with read word0 on the pins; ce moves off a link rise
      drain();
      issue(1'b0, 2, 4'h0, 4'h0);
      repeat (6) @(posedge clock);
      ce <= 1'b0;
      @(negedge clock);
      hold_dq = link_bus.dq;
      repeat (20) @(negedge clock);
      check("stopped_dq", {36'h0, hold_dq}, {36'h0, link_bus.dq});
      check("stopped_word", {36'h0, exp_q[0][71:36]}, {36'h0, hold_dq});
      @(posedge clock);
      ce <= 1'b1;
      for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge clock);
      check("reads_pending", 72'h0, 72'(exp_q.size()));
      test_done();
   end
endmodule
